// ### src/metering_irq_status_enable_a.sv
// Channel A and voltage interrupt flags, enables and irq output
`timescale 1ns/100ps
`default_nettype none

module metering_irq_status_enable_a (
  input wire logic core_clk,
  input wire logic arst_n,
  // Event pulses from the metering core, one cycle each
  input wire logic active_energy_half_full,
  input wire logic reactive_energy_half_full,
  input wire logic apparent_energy_half_full,
  input wire logic active_energy_overflow,
  input wire logic reactive_energy_overflow,
  input wire logic apparent_energy_overflow,
  input wire logic active_power_no_load,
  input wire logic reactive_power_no_load,
  input wire logic apparent_power_no_load,
  input wire logic active_sign_change,
  input wire logic reactive_sign_change,
  input wire logic current_crossing_timeout,
  input wire logic current_crossing_event,
  input wire logic overcurrent_event,
  input wire logic voltage_crossing_timeout,
  input wire logic voltage_crossing_event,
  input wire logic overvoltage_event,
  input wire logic new_waveform_sample,
  input wire logic line_cycle_end,
  input wire logic sag_event,
  input wire logic soft_reset_done,
  input wire logic checksum_change,
  // Register port from the serial interface logic
  input wire logic [irq_chan_a_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [irq_chan_a_pkg::DATA_W-1:0] reg_wdata,
  output logic [irq_chan_a_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic irq_n
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_n;

  reset_release_sync #(
    .STAGES(irq_chan_a_pkg::RST_STAGES)
  ) u_rst_sync (
    .clk(core_clk),
    .arst_n(arst_n),
    .rst_n(rst_n)
  );

  // ----------------------------------------------------------------
  // Event vector
  // ----------------------------------------------------------------
  localparam int N = irq_chan_a_pkg::EVENT_COUNT;
  localparam int PAD = irq_chan_a_pkg::DATA_W - N;

  logic [N-1:0] evt;
  logic boot_q;
  logic boot_pulse;

  // One pulse in the first cycle after reset release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_q <= 1'b0;
    end else begin
      boot_q <= 1'b1;
    end
  end

  assign boot_pulse = ~boot_q;

  // Map each core event onto its flag position
  assign evt[irq_chan_a_pkg::BIT_ACT_HALF] = active_energy_half_full;
  assign evt[irq_chan_a_pkg::BIT_REACT_HALF] =
    reactive_energy_half_full;
  assign evt[irq_chan_a_pkg::BIT_APP_HALF] =
    apparent_energy_half_full;
  assign evt[irq_chan_a_pkg::BIT_ACT_OVF] = active_energy_overflow;
  assign evt[irq_chan_a_pkg::BIT_REACT_OVF] =
    reactive_energy_overflow;
  assign evt[irq_chan_a_pkg::BIT_APP_OVF] =
    apparent_energy_overflow;
  assign evt[irq_chan_a_pkg::BIT_ACT_NOLOAD] = active_power_no_load;
  assign evt[irq_chan_a_pkg::BIT_REACT_NOLOAD] =
    reactive_power_no_load;
  assign evt[irq_chan_a_pkg::BIT_APP_NOLOAD] =
    apparent_power_no_load;
  assign evt[irq_chan_a_pkg::BIT_ACT_SIGN] = active_sign_change;
  assign evt[irq_chan_a_pkg::BIT_REACT_SIGN] = reactive_sign_change;
  assign evt[irq_chan_a_pkg::BIT_CUR_TIMEOUT] =
    current_crossing_timeout;
  assign evt[irq_chan_a_pkg::BIT_CUR_CROSS] =
    current_crossing_event;
  assign evt[irq_chan_a_pkg::BIT_OVERCURRENT] = overcurrent_event;
  assign evt[irq_chan_a_pkg::BIT_VOLT_TIMEOUT] =
    voltage_crossing_timeout;
  assign evt[irq_chan_a_pkg::BIT_VOLT_CROSS] =
    voltage_crossing_event;
  assign evt[irq_chan_a_pkg::BIT_OVERVOLTAGE] = overvoltage_event;
  assign evt[irq_chan_a_pkg::BIT_WAVE_SAMPLE] = new_waveform_sample;
  assign evt[irq_chan_a_pkg::BIT_CYCLE_END] = line_cycle_end;
  assign evt[irq_chan_a_pkg::BIT_SAG] = sag_event;
  // Hardware reset completes at release, software reset via the core
  assign evt[irq_chan_a_pkg::BIT_RESET_DONE] =
    soft_reset_done | boot_pulse;
  assign evt[irq_chan_a_pkg::BIT_CHECKSUM] = checksum_change;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic hit_en;
  logic hit_plain;
  logic hit_clr;
  logic clr_read;

  // Both copies of each register decode to the same storage
  assign hit_en = (reg_addr == irq_chan_a_pkg::EN_SHORT_ADDR) ||
                  (reg_addr == irq_chan_a_pkg::EN_LONG_ADDR);
  assign hit_plain = (reg_addr == irq_chan_a_pkg::FLAGS_SHORT_ADDR) ||
                     (reg_addr == irq_chan_a_pkg::FLAGS_LONG_ADDR);
  assign hit_clr = (reg_addr == irq_chan_a_pkg::CLR_SHORT_ADDR) ||
                   (reg_addr == irq_chan_a_pkg::CLR_LONG_ADDR);
  assign clr_read = reg_rd & hit_clr;

  // ----------------------------------------------------------------
  // Enable register
  // ----------------------------------------------------------------
  logic [N-1:0] en_q;

  // Writes only land on an enable address; the reset enable is pinned
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= irq_chan_a_pkg::EN_RESET;
    end else if (reg_wr && hit_en) begin
      en_q <= reg_wdata[N-1:0] | irq_chan_a_pkg::EN_FORCED;
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  logic [N-1:0] flags_q;
  logic [N-1:0] flags_d;

  // Set wins over a clear-on-read in the same cycle, so no event is lost
  for (genvar i = 0; i < N; i++) begin : g_flag
    assign flags_d[i] = evt[i] | (flags_q[i] & ~clr_read);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= irq_chan_a_pkg::FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [N-1:0] rd_mux;

  // Flag reads show the value before any clear; unmapped reads give zero
  always_comb begin
    rd_mux = '0;
    if (hit_en) begin
      rd_mux = en_q;
    end else if (hit_plain || hit_clr) begin
      rd_mux = flags_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= {{PAD{1'b0}}, rd_mux};
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  logic [N-1:0] pending;

  // Registered so the pin never glitches; costs one cycle of latency
  assign pending = flags_q & en_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= ~(|pending);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Energy, no-load and sign events land in their flags by the next cycle
  half_full_set_a: assert property (
    evt[2:0] != 3'h0 |=> (flags_q[2:0] & $past(evt[2:0])) ==
      $past(evt[2:0]))
    else $error("half-full event did not set its flag");

  overflow_set_a: assert property (
    evt[5:3] != 3'h0 |=> (flags_q[5:3] & $past(evt[5:3])) ==
      $past(evt[5:3]))
    else $error("overflow event did not set its flag");

  no_load_set_a: assert property (
    evt[8:6] != 3'h0 |=> (flags_q[8:6] & $past(evt[8:6])) ==
      $past(evt[8:6]))
    else $error("no-load event did not set its flag");

  sign_set_a: assert property (
    active_sign_change && reactive_sign_change |=>
      flags_q[10:9] == 2'h3)
    else $error("sign change flags not both set");

  // A flag set by its event stays until a clearing read
  crossing_hold_a: assert property (
    current_crossing_event ##1 !clr_read [*3] |=> flags_q[12])
    else $error("current crossing flag did not hold");

  volt_timeout_a: assert property (
    voltage_crossing_timeout && clr_read |=> flags_q[14])
    else $error("clear beat a voltage timeout event");

  cycle_sample_a: assert property (
    new_waveform_sample ##1 line_cycle_end && !clr_read |=>
      flags_q[18:17] == 2'h3)
    else $error("sample or cycle end flag lost");

  // The release pulse raises the reset-done flag and the interrupt
  boot_flag_a: assert property (
    $rose(boot_q) |-> flags_q[20] ##1 !irq_n)
    else $error("reset completion not flagged");

  // The fixed enable survives every write and shows on every enable read
  reset_en_fixed_a: assert property (
    reg_wr && hit_en |=> en_q[irq_chan_a_pkg::BIT_RESET_DONE])
    else $error("reset-done enable turned off");

  enable_read_a: assert property (
    reg_rd && hit_en |=> reg_rdata[irq_chan_a_pkg::BIT_RESET_DONE])
    else $error("reset-done enable read back as zero");

  // Two quiet cycles of pending must leave the line released
  irq_quiet_a: assert property (
    (pending == '0) [*2] |-> irq_n)
    else $error("irq asserted with nothing enabled");

  irq_raise_a: assert property (
    pending != '0 |=> !irq_n)
    else $error("irq not asserted for enabled flag");

  en_mirror_a: assert property (
    reg_wr && reg_addr == irq_chan_a_pkg::EN_LONG_ADDR ##1
      !(reg_wr && hit_en) ##1
      reg_rd && reg_addr == irq_chan_a_pkg::EN_SHORT_ADDR |=>
      reg_rdata[N-1:0] == ($past(reg_wdata[N-1:0], 3) |
      irq_chan_a_pkg::EN_FORCED))
    else $error("enable copies disagree");

  plain_read_a: assert property (
    reg_rd && hit_plain |=> reg_rvalid &&
      reg_rdata == {{PAD{1'b0}}, $past(flags_q)} &&
      (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("plain read wrong or disturbed flags");

  clear_read_a: assert property (
    clr_read && evt == '0 |=> flags_q == '0 &&
      reg_rdata[N-1:0] == $past(flags_q))
    else $error("clear-on-read did not return then clear");

  unmapped_read_a: assert property (
    reg_rd && !hit_en && !hit_plain && !hit_clr |=>
      reg_rvalid && reg_rdata == '0)
    else $error("unmapped read returned data");

  // Timeout, peak, sag and checksum events land in their flags; reset
  // done is left out as its release pulse races the lifting disable
  other_set_a: assert property (
    (evt & 22'h2ff800) != 22'h0 |=>
      (flags_q & $past(evt & 22'h2ff800)) == $past(evt & 22'h2ff800))
    else $error("event did not set its flag");

  // Only a clearing read may drop a flag
  flag_hold_a: assert property (
    !clr_read |=> (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("flag dropped without a clearing read");

  // Writes to any other place must leave the enable alone
  en_stable_a: assert property (
    !(reg_wr && hit_en) |=> $stable(en_q))
    else $error("enable changed without an enable write");

  rvalid_pulse_a: assert property (
    !reg_rd |=> !reg_rvalid)
    else $error("read answer without a read");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  clear_busy_c: cover property (clr_read && flags_q != '0);

  clear_race_c: cover property (clr_read && evt != '0);

  irq_cycle_c: cover property ($fell(irq_n) ##[1:50] $rose(irq_n));

  en_write_c: cover property (reg_wr && hit_en && reg_wdata[0]);

endmodule : metering_irq_status_enable_a

`default_nettype wire

// ### src/irq_chan_a_pkg.sv
// Constants shared by the channel A interrupt flag and enable logic
package irq_chan_a_pkg;

  // ----------------------------------------------------------------
  // Register port shape
  // ----------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int EVENT_COUNT = 22;
  localparam int RST_STAGES = 2;

  // ----------------------------------------------------------------
  // Register addresses, short and long copies of each
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] EN_SHORT_ADDR = 10'h22c;
  localparam logic [ADDR_W-1:0] FLAGS_SHORT_ADDR = 10'h22d;
  localparam logic [ADDR_W-1:0] CLR_SHORT_ADDR = 10'h22e;
  localparam logic [ADDR_W-1:0] EN_LONG_ADDR = 10'h32c;
  localparam logic [ADDR_W-1:0] FLAGS_LONG_ADDR = 10'h32d;
  localparam logic [ADDR_W-1:0] CLR_LONG_ADDR = 10'h32e;

  // ----------------------------------------------------------------
  // Event bit positions in the flag and enable registers
  // ----------------------------------------------------------------
  localparam int BIT_ACT_HALF = 0;
  localparam int BIT_REACT_HALF = 1;
  localparam int BIT_APP_HALF = 2;
  localparam int BIT_ACT_OVF = 3;
  localparam int BIT_REACT_OVF = 4;
  localparam int BIT_APP_OVF = 5;
  localparam int BIT_ACT_NOLOAD = 6;
  localparam int BIT_REACT_NOLOAD = 7;
  localparam int BIT_APP_NOLOAD = 8;
  localparam int BIT_ACT_SIGN = 9;
  localparam int BIT_REACT_SIGN = 10;
  localparam int BIT_CUR_TIMEOUT = 11;
  localparam int BIT_CUR_CROSS = 12;
  localparam int BIT_OVERCURRENT = 13;
  localparam int BIT_VOLT_TIMEOUT = 14;
  localparam int BIT_VOLT_CROSS = 15;
  localparam int BIT_OVERVOLTAGE = 16;
  localparam int BIT_WAVE_SAMPLE = 17;
  localparam int BIT_CYCLE_END = 18;
  localparam int BIT_SAG = 19;
  localparam int BIT_RESET_DONE = 20;
  localparam int BIT_CHECKSUM = 21;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  // Enable bits that software can never turn off
  localparam logic [EVENT_COUNT-1:0] EN_FORCED = 22'h100000;
  localparam logic [EVENT_COUNT-1:0] EN_RESET = EN_FORCED;
  localparam logic [EVENT_COUNT-1:0] FLAGS_RESET = 22'h000000;

endpackage : irq_chan_a_pkg

// ### src/reset_release_sync.sv
// Reset release synchroniser: async assert, clocked release
`timescale 1ns/100ps
`default_nettype none

module reset_release_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  output logic rst_n
);

  // ----------------------------------------------------------------
  // Shift chain
  // ----------------------------------------------------------------
  logic [STAGES-1:0] chain_q;

  // Ones shift in after release so the deassertion is clean
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chain_q <= '0;
    end else begin
      chain_q <= {chain_q[STAGES-2:0], 1'b1};
    end
  end

  assign rst_n = chain_q[STAGES-1];

endmodule : reset_release_sync

`default_nettype wire

// ### sim/irq_host_model.sv
// Host model that reaches the flag and enable registers
`timescale 1ns/100ps
`default_nettype none

module irq_host_model (
  input wire logic core_clk,
  output logic [irq_chan_a_pkg::ADDR_W-1:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [irq_chan_a_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [irq_chan_a_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  // ----------------------------------------------------------------
  // Idle bus
  // ----------------------------------------------------------------
  // A released bus shows the inverse of the last request, not a copy
  initial begin
    reg_addr = 10'h000;
    reg_wdata = 32'h00000000;
    reg_rd = 1'h0;
    reg_wr = 1'h0;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  // Write one word; a one in the enable lets that event interrupt
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge core_clk);
    reg_wr = 1'h0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  // Read one word; the answer is looked at in its only valid cycle
  task automatic rd(input logic [9:0] a, output logic [31:0] d,
                    output logic v);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge core_clk);
    reg_rd = 1'h0;
    reg_addr = ~a;
    v = reg_rvalid;
    d = reg_rdata;
  endtask : rd
endmodule : irq_host_model

`default_nettype wire

// ### sim/metering_irq_status_enable_a_test.sv
// Self-checking bench for the channel A flag and enable logic
`timescale 1ns/100ps
`default_nettype none

module metering_irq_status_enable_a_test;
  logic core_clk;
  logic arst_n;
  logic [21:0] ev;
  logic [9:0] reg_addr;
  logic reg_rd;
  logic reg_wr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic irq_n;
  int err_total;
  int n_tests;
  int cycles;

  metering_irq_status_enable_a metering_irq_status_enable_a_inst (
    .core_clk(core_clk), .arst_n(arst_n),
    .active_energy_half_full(ev[0]), .reactive_energy_half_full(ev[1]),
    .apparent_energy_half_full(ev[2]), .active_energy_overflow(ev[3]),
    .reactive_energy_overflow(ev[4]), .apparent_energy_overflow(ev[5]),
    .active_power_no_load(ev[6]), .reactive_power_no_load(ev[7]),
    .apparent_power_no_load(ev[8]), .active_sign_change(ev[9]),
    .reactive_sign_change(ev[10]), .current_crossing_timeout(ev[11]),
    .current_crossing_event(ev[12]), .overcurrent_event(ev[13]),
    .voltage_crossing_timeout(ev[14]), .voltage_crossing_event(ev[15]),
    .overvoltage_event(ev[16]), .new_waveform_sample(ev[17]),
    .line_cycle_end(ev[18]), .sag_event(ev[19]),
    .soft_reset_done(ev[20]), .checksum_change(ev[21]),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .irq_n(irq_n)
  );

  irq_host_model irq_host_model_inst (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid)
  );

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  // 20 MHz clock
  always #25 core_clk = ~core_clk;

  // The tests need under a thousand cycles; 5000 means a hang
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total = err_total + 1;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Compare and count
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", name, exp, got);
      err_total = err_total + 1;
    end
  endtask : check

  // Read and compare both the answer strobe and the data
  task automatic rchk(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic v;
    irq_host_model_inst.rd(a, d, v);
    check("rvalid", 32'h1, {31'h0, v});
    check($sformatf("rdata@%h", a), exp, d);
  endtask : rchk

  // One-cycle event pulse
  task automatic pulse(input int b);
    @(negedge core_clk);
    ev[b] = 1'h1;
    @(negedge core_clk);
    ev[b] = 1'h0;
  endtask : pulse

  // Verdict, the only place the run ends
  task automatic finish_test();
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] m;
    core_clk = 1'h0;
    arst_n = 1'h0;
    ev = 22'h000000;
    err_total = 0;
    n_tests = 0;
    cycles = 0;
    repeat (16) @(negedge core_clk);
    arst_n = 1'h1;
    repeat (6) @(negedge core_clk);
    // Hardware reset done flag raises irq through the fixed enable
    check("irq_n", 32'h0, {31'h0, irq_n});
    rchk(10'h22c, 32'h00100000);
    rchk(10'h22d, 32'h00100000);
    rchk(10'h32d, 32'h00100000);
    rchk(10'h32e, 32'h00100000);
    rchk(10'h22d, 32'h00000000);
    @(negedge core_clk);
    check("irq_n", 32'h1, {31'h0, irq_n});
    // Bits above 21 read 0; bit 20 cannot be switched off
    irq_host_model_inst.wr(10'h22c, 32'hffffffff);
    rchk(10'h32c, 32'h003fffff);
    irq_host_model_inst.wr(10'h32c, 32'h00000000);
    rchk(10'h22c, 32'h00100000);
    // Unmapped places ignore writes and read back 0
    irq_host_model_inst.wr(10'h22d, 32'h00000001);
    irq_host_model_inst.wr(10'h100, 32'h00000001);
    rchk(10'h100, 32'h00000000);
    rchk(10'h22c, 32'h00100000);
    // Each event, masked (bit 20 cannot be) and then enabled
    for (int b = 0; b < 22; b++) begin
      m = 32'h1 << b;
      pulse(b);
      @(negedge core_clk);
      check("irq_n masked", (b == 20) ? 32'h0 : 32'h1,
            {31'h0, irq_n});
      rchk(10'h22d, m);
      rchk(10'h32e, m);
      rchk(10'h32d, 32'h00000000);
      irq_host_model_inst.wr((b % 2) ? 10'h22c : 10'h32c, m);
      rchk((b % 2) ? 10'h32c : 10'h22c, m | 32'h00100000);
      pulse(b);
      @(negedge core_clk);
      check("irq_n enabled", 32'h0, {31'h0, irq_n});
      rchk(10'h22e, m);
      repeat (2) @(negedge core_clk);
      check("irq_n cleared", 32'h1, {31'h0, irq_n});
      irq_host_model_inst.wr(10'h22c, 32'h00000000);
    end
    // Two events at once, then two on adjacent edges
    @(negedge core_clk);
    ev = 22'h000600;
    @(negedge core_clk);
    ev = 22'h020000;
    @(negedge core_clk);
    ev = 22'h040000;
    @(negedge core_clk);
    ev = 22'h000000;
    rchk(10'h22d, 32'h00060600);
    // An event on the edge of a clearing read must survive it
    fork
      rchk(10'h32e, 32'h00060600);
      pulse(14);
    join
    rchk(10'h22d, 32'h00004000);
    rchk(10'h22e, 32'h00004000);
    // Reset in mid-run: enable back to its reset value, reset flagged
    irq_host_model_inst.wr(10'h22c, 32'h003fffff);
    @(negedge core_clk);
    arst_n = 1'h0;
    repeat (2) @(negedge core_clk);
    check("irq_n in reset", 32'h1, {31'h0, irq_n});
    check("rvalid in reset", 32'h0, {31'h0, reg_rvalid});
    arst_n = 1'h1;
    repeat (6) @(negedge core_clk);
    check("irq_n after reset", 32'h0, {31'h0, irq_n});
    rchk(10'h32c, 32'h00100000);
    rchk(10'h22e, 32'h00100000);
    finish_test();
  end
endmodule : metering_irq_status_enable_a_test

`default_nettype wire
